// ===== inc/vlg_params.svh
// Register offsets, field positions and reset values of the line geometry block
`ifndef VLG_PARAMS_SVH
`define VLG_PARAMS_SVH
`define VLG_OFS_IMG_PITCH   32'h0000_0000
`define VLG_OFS_HANC_PITCH  32'h0000_0004
`define VLG_OFS_HSIZE       32'h0000_0008
`define VLG_OFS_VMARKS0     32'h0000_000c
`define VLG_OFS_CTRL        32'h0000_0010
`define VLG_OFS_AREA_START  32'h0000_0014
`define VLG_OFS_STATUS      32'h0000_0018
`define VLG_RST_REG         32'h0000_0000
`define VLG_HSIZE_MASK      32'h1fff_1fff
`define VLG_VMARKS_MASK     32'h0fff_0fff
`define VLG_CTRL_MASK       32'h0000_000f
`define VLG_CTRL_RASTER     0
`define VLG_CTRL_YC_MUX     1
`define VLG_CTRL_FMT_HI     3
`define VLG_CTRL_FMT_LO     2
`define VLG_BLANK_HI        28
`define VLG_BLANK_LO        16
`define VLG_ACT_HI          12
`define VLG_ACT_LO          0
`define VLG_MARK_A_HI       27
`define VLG_MARK_A_LO       16
`define VLG_MARK_B_HI       11
`define VLG_MARK_B_LO       0
`define VLG_STAT_MISMATCH   31
`define VLG_CODE_PREAMBLE   24'hff_00_00
`define VLG_CODE_LEN        16'h0003
`define VLG_CODE_H_BIT      4
`define VLG_RESP_OKAY       2'h0
`define VLG_RESP_SLVERR     2'h2
`endif

// ===== inc/vlg_pkg.sv
// Types of the video line geometry block
`default_nettype none
package vlg_pkg;
  typedef enum logic [1:0] {PH_IDLE, PH_BLANK, PH_ACTIVE} vlg_phase_e;
  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } vlg_axi_req_s;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } vlg_axi_rsp_s;
  typedef struct packed {
    logic        active;
    logic        blank;
    logic [7:0]  data;
    logic [11:0] line;
    logic        mark_a;
    logic        mark_b;
    logic [31:0] img_addr;
    logic [31:0] vanc_addr;
    logic [31:0] hanc_addr;
  } vlg_geo_s;
  typedef struct packed {
    vlg_axi_rsp_s rsp;
    logic         aw_got;
    logic         w_got;
    logic [31:0]  awaddr;
    logic [31:0]  wdata;
    logic [3:0]   wstrb;
    logic [31:0]  img_pitch;
    logic [31:0]  hanc_pitch;
    logic [31:0]  hsize;
    logic [31:0]  vmarks;
    logic [31:0]  ctrl;
    logic [31:0]  area_start;
    logic         mismatch;
    vlg_phase_e   phase;
    logic [15:0]  pos;
    logic [23:0]  hist;
    logic         line_seen;
    logic [11:0]  line;
    logic [31:0]  img_off;
    logic [31:0]  vanc_off;
    logic [31:0]  hanc_off;
    vlg_geo_s     geo;
  } vlg_state_s;
endpackage : vlg_pkg
`default_nettype wire

// ===== src/vlg_top.sv
// Video capture line geometry: register slave, line timing and line addresses
`default_nettype none
`include "vlg_params.svh"
// Summary of operation
// - Image pitch register holds 32-bit line offset
// - Pitches apply only in raster storage
// - Multiplexed luma/chroma: ancillary offset doubles pitch
// - Separate luma/chroma: ancillary offset equals pitch
// - Raw capture uses channel zero image pitch
// - Horizontal ancillary pitch register, 32-bit offset
// - Widths exclude the four-byte timing codes
// - Y/C blank width: end code to start code
// - Y/C active width: start code to end code
// - Raw mode blank width is blanking length
// - Raw mode active width is picture size
// - Raw mode delimits areas from counts only
// - Line marks take effect immediately when written
// - Line counter starts at one
// - Mark register: two 12-bit positions, rest zero
module vlg_top #(
  parameter int unsigned CHANNEL = 0
) (
  input  wire logic                  mclk_in,
  input  wire logic                  rst_in,
  input  wire vlg_pkg::vlg_axi_req_s axi_req_in,
  output var  vlg_pkg::vlg_axi_rsp_s axi_rsp_out,
  input  wire logic                  pix_vld_in,
  input  wire logic [7:0]            pix_data_in,
  input  wire logic                  line_start_in,
  input  wire logic                  frame_start_in,
  input  wire logic [31:0]           ch0_pitch_in,
  output var  vlg_pkg::vlg_geo_s     geo_out
);

  vlg_pkg::vlg_state_s s;
  vlg_pkg::vlg_state_s next_s;
  logic                wr_en;
  logic                adv;
  logic                yc;
  logic                raw;
  logic                raster;
  logic [15:0]         bw;
  logic [15:0]         aw;
  logic [31:0]         pitch_img;
  logic [31:0]         img_step;
  logic [31:0]         vanc_step;
  logic [31:0]         hanc_step;
  logic [32:0]         rd;
  logic [32:0]         wr_hit;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Bit 32 flags a mapped address
  function automatic logic [32:0] rd_word(input vlg_pkg::vlg_state_s st,
                                          input logic [31:0] addr);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    case (addr)
      `VLG_OFS_IMG_PITCH:  r[31:0] = st.img_pitch;
      `VLG_OFS_HANC_PITCH: r[31:0] = st.hanc_pitch;
      `VLG_OFS_HSIZE:      r[31:0] = st.hsize;
      `VLG_OFS_VMARKS0:    r[31:0] = st.vmarks;
      `VLG_OFS_CTRL:       r[31:0] = st.ctrl;
      `VLG_OFS_AREA_START: r[31:0] = st.area_start;
      `VLG_OFS_STATUS:
      begin
        r[31:0] = {st.mismatch, 14'h0000, st.phase == vlg_pkg::PH_ACTIVE, 4'h0, st.line};
      end
      default:             r = {1'b0, 32'h0000_0000};
    endcase
    return r;
  endfunction : rd_word

  always_comb
  begin
    next_s = s;
    wr_en  = 1'b0;
    adv    = 1'b0;
    yc     = s.ctrl[`VLG_CTRL_FMT_HI:`VLG_CTRL_FMT_LO] == 2'h0;
    raw    = s.ctrl[`VLG_CTRL_FMT_HI];
    raster = s.ctrl[`VLG_CTRL_RASTER];
    bw     = {3'h0, s.hsize[`VLG_BLANK_HI:`VLG_BLANK_LO]};
    aw     = {3'h0, s.hsize[`VLG_ACT_HI:`VLG_ACT_LO]};
    rd     = rd_word(s, axi_req_in.araddr);
    wr_hit = rd_word(s, s.awaddr);
    // Other channels borrow the channel zero pitch for raw data
    pitch_img = (raw && CHANNEL != 0) ? ch0_pitch_in : s.img_pitch;
    img_step  = raster ? pitch_img : 32'h0000_0000;
    vanc_step = 32'h0000_0000;
    if (raster)
    begin
      vanc_step = s.ctrl[`VLG_CTRL_YC_MUX] ? {s.img_pitch[30:0], 1'b0}
                                           : s.img_pitch;
    end
    hanc_step = raster ? s.hanc_pitch : 32'h0000_0000;

    // Write address and data, taken in either order
    if (axi_req_in.awvalid && s.rsp.awready)
    begin
      next_s.aw_got      = 1'b1;
      next_s.awaddr      = axi_req_in.awaddr;
      next_s.rsp.awready = 1'b0;
    end
    if (axi_req_in.wvalid && s.rsp.wready)
    begin
      next_s.w_got      = 1'b1;
      next_s.wdata      = axi_req_in.wdata;
      next_s.wstrb      = axi_req_in.wstrb;
      next_s.rsp.wready = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.rsp.bvalid)
    begin
      wr_en             = 1'b1;
      next_s.aw_got     = 1'b0;
      next_s.w_got      = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp  = wr_hit[32] ? `VLG_RESP_OKAY : `VLG_RESP_SLVERR;
      case (s.awaddr)
        `VLG_OFS_IMG_PITCH:  next_s.img_pitch = merge(s.img_pitch, s.wdata, s.wstrb);
        `VLG_OFS_HANC_PITCH: next_s.hanc_pitch = merge(s.hanc_pitch, s.wdata, s.wstrb);
        `VLG_OFS_HSIZE:
        begin
          next_s.hsize = merge(s.hsize, s.wdata, s.wstrb) & `VLG_HSIZE_MASK;
        end
        `VLG_OFS_VMARKS0:
        begin
          next_s.vmarks = merge(s.vmarks, s.wdata, s.wstrb) & `VLG_VMARKS_MASK;
        end
        `VLG_OFS_CTRL:
        begin
          next_s.ctrl = merge(s.ctrl, s.wdata, s.wstrb) & `VLG_CTRL_MASK;
        end
        `VLG_OFS_AREA_START: next_s.area_start = merge(s.area_start, s.wdata, s.wstrb);
        `VLG_OFS_STATUS:
        begin
          if (s.wstrb[3] && s.wdata[`VLG_STAT_MISMATCH])
          begin
            next_s.mismatch = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (s.rsp.bvalid && axi_req_in.bready)
    begin
      next_s.rsp.bvalid  = 1'b0;
      next_s.rsp.awready = 1'b1;
      next_s.rsp.wready  = 1'b1;
    end

    // Reads answer one cycle after the address is taken
    if (axi_req_in.arvalid && s.rsp.arready)
    begin
      next_s.rsp.arready = 1'b0;
      next_s.rsp.rvalid  = 1'b1;
      next_s.rsp.rdata   = rd[31:0];
      next_s.rsp.rresp   = rd[32] ? `VLG_RESP_OKAY : `VLG_RESP_SLVERR;
    end
    if (s.rsp.rvalid && axi_req_in.rready)
    begin
      next_s.rsp.rvalid  = 1'b0;
      next_s.rsp.arready = 1'b1;
    end

    // Pixel side; status sets below override a software clear
    next_s.geo.active = 1'b0;
    next_s.geo.blank  = 1'b0;
    next_s.geo.data   = pix_data_in;
    if (frame_start_in)
    begin
      next_s.line      = 12'h001;
      next_s.line_seen = 1'b0;
      next_s.img_off   = 32'h0000_0000;
      next_s.vanc_off  = 32'h0000_0000;
      next_s.hanc_off  = 32'h0000_0000;
      next_s.phase     = vlg_pkg::PH_IDLE;
      next_s.pos       = 16'h0000;
    end
    else if (raw && line_start_in)
    begin
      adv              = s.line_seen;
      next_s.line_seen = 1'b1;
      next_s.pos       = 16'h0000;
      next_s.phase     = vlg_pkg::PH_BLANK;
    end
    else if (pix_vld_in && (yc || raw))
    begin
      next_s.hist = {s.hist[15:0], pix_data_in};
      if (yc && s.hist == `VLG_CODE_PREAMBLE)
      begin
        // Count restarts after the code so widths exclude it
        next_s.pos = 16'h0000;
        if (pix_data_in[`VLG_CODE_H_BIT])
        begin
          if (s.phase == vlg_pkg::PH_ACTIVE && s.pos != aw + `VLG_CODE_LEN)
          begin
            next_s.mismatch = 1'b1;
          end
          adv              = s.line_seen;
          next_s.line_seen = 1'b1;
          next_s.phase     = vlg_pkg::PH_BLANK;
        end
        else
        begin
          if (s.phase == vlg_pkg::PH_BLANK && s.pos != bw + `VLG_CODE_LEN)
          begin
            next_s.mismatch = 1'b1;
          end
          next_s.phase = vlg_pkg::PH_ACTIVE;
        end
      end
      else if (s.phase != vlg_pkg::PH_IDLE)
      begin
        next_s.pos = s.pos + 16'h0001;
        if (raw)
        begin
          next_s.geo.blank  = s.pos < bw;
          next_s.geo.active = s.pos >= bw && s.pos < bw + aw;
          next_s.phase      = (s.pos + 16'h0001 < bw) ? vlg_pkg::PH_BLANK
                                                      : vlg_pkg::PH_ACTIVE;
        end
        else if (s.phase == vlg_pkg::PH_BLANK)
        begin
          next_s.geo.blank = 1'b1;
        end
        else
        begin
          next_s.geo.active = s.pos < aw;
        end
      end
    end
    if (adv)
    begin
      next_s.line     = s.line + 12'h001;
      next_s.img_off  = s.img_off + img_step;
      next_s.vanc_off = s.vanc_off + vanc_step;
      next_s.hanc_off = s.hanc_off + hanc_step;
    end

    // Marks compare against the live register, no shadow copy
    next_s.geo.mark_a    = s.line == s.vmarks[`VLG_MARK_A_HI:`VLG_MARK_A_LO];
    next_s.geo.mark_b    = s.line == s.vmarks[`VLG_MARK_B_HI:`VLG_MARK_B_LO];
    next_s.geo.line      = s.line;
    next_s.geo.img_addr  = s.area_start + s.img_off;
    next_s.geo.vanc_addr = s.area_start + s.vanc_off;
    next_s.geo.hanc_addr = s.area_start + s.hanc_off;
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s             <= '0;
      s.img_pitch   <= `VLG_RST_REG;
      s.hanc_pitch  <= `VLG_RST_REG;
      s.hsize       <= `VLG_RST_REG;
      s.vmarks      <= `VLG_RST_REG;
      s.ctrl        <= `VLG_RST_REG;
      s.area_start  <= `VLG_RST_REG;
      s.line        <= 12'h001;
      s.rsp.awready <= 1'b1;
      s.rsp.wready  <= 1'b1;
      s.rsp.arready <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign axi_rsp_out = s.rsp;
  assign geo_out     = s.geo;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_adv;
    adv;
  endsequence

  sequence s_vm_wr;
    wr_en && s.awaddr == `VLG_OFS_VMARKS0 && s.wstrb == 4'hf;
  endsequence

  property p_img_step;
    s_adv ##0 raster |=> s.img_off == $past(s.img_off) + $past(pitch_img);
  endproperty
  a_img_step: assert property (p_img_step) else $error("image offset step wrong");

  property p_subpic;
    s_adv ##0 !raster |=> s.img_off == $past(s.img_off) && s.hanc_off == $past(s.hanc_off);
  endproperty
  a_subpic: assert property (p_subpic) else $error("pitch used outside raster");

  property p_vanc_mux;
    s_adv ##0 (raster && s.ctrl[`VLG_CTRL_YC_MUX])
      |=> s.vanc_off == $past(s.vanc_off) + {$past(s.img_pitch[30:0]), 1'b0};
  endproperty
  a_vanc_mux: assert property (p_vanc_mux) else $error("ancillary step not doubled");

  property p_vanc_sep;
    s_adv ##0 (raster && !s.ctrl[`VLG_CTRL_YC_MUX])
      |=> s.vanc_off == $past(s.vanc_off) + $past(s.img_pitch);
  endproperty
  a_vanc_sep: assert property (p_vanc_sep) else $error("ancillary step not pitch");

  property p_hanc;
    s_adv ##0 raster
      |=> s.hanc_off == $past(s.hanc_off) + $past(s.hanc_pitch);
  endproperty
  a_hanc: assert property (p_hanc) else $error("hanc address wrong");

  property p_raw_blank;
    raw && pix_vld_in && !line_start_in && !frame_start_in && s.phase != vlg_pkg::PH_IDLE
      && s.pos < bw |=> geo_out.blank && !geo_out.active;
  endproperty
  a_raw_blank: assert property (p_raw_blank) else $error("raw blanking missed");

  property p_raw_active;
    raw && pix_vld_in && !line_start_in && !frame_start_in && s.phase != vlg_pkg::PH_IDLE
      && s.pos >= bw && s.pos < bw + aw |=> geo_out.active && !geo_out.blank;
  endproperty
  a_raw_active: assert property (p_raw_active) else $error("raw picture missed");

  property p_line_one;
    frame_start_in |=> s.line == 12'h001 ##1 geo_out.line == 12'h001;
  endproperty
  a_line_one: assert property (p_line_one) else $error("line count not from one");

  property p_mark_now;
    s_vm_wr ##1 (s.line == s.vmarks[`VLG_MARK_A_HI:`VLG_MARK_A_LO]) |=> geo_out.mark_a;
  endproperty
  a_mark_now: assert property (p_mark_now) else $error("mark not applied at once");

endmodule : vlg_top
`default_nettype wire

// ===== verification/vlg_pix_src.sv
// Pixel source model: raw sensor lines and Y/C lines with timing codes
`default_nettype none
module vlg_pix_src (
  input  wire logic       mclk_in,
  output var  logic       vld_out,
  output var  logic [7:0] data_out,
  output var  logic       line_start_out,
  output var  logic       frame_start_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    vld_out = 1'b0;
    data_out = 8'h00;
    line_start_out = 1'b0;
    frame_start_out = 1'b0;
  end
  // Each idle put inverts the bus, so idle runs alternate between the inverted and the last byte
  task automatic put(input logic [7:0] b, input logic v, input logic ls, input logic fs);
    @(posedge mclk_in);
    vld_out <= v;
    data_out <= v ? b : ~data_out;
    line_start_out <= ls;
    frame_start_out <= fs;
  endtask : put
  task automatic frame();
    put(8'h00, 1'b0, 1'b0, 1'b1);
    put(8'h00, 1'b0, 1'b0, 1'b0);
  endtask : frame
  // Raw line carries no timing codes
  task automatic raw_line(input int n);
    put(8'h00, 1'b0, 1'b1, 1'b0);
    for (int k = 0; k < n; k++)
      put(8'h20 + 8'(k), 1'b1, 1'b0, 1'b0);
    put(8'h00, 1'b0, 1'b0, 1'b0);
  endtask : raw_line
  task automatic code(input logic end_code);
    put(8'hff, 1'b1, 1'b0, 1'b0);
    put(8'h00, 1'b1, 1'b0, 1'b0);
    put(8'h00, 1'b1, 1'b0, 1'b0);
    put({3'b100, end_code, 4'h0}, 1'b1, 1'b0, 1'b0);
  endtask : code
  task automatic yc_line(input int nb, input int na);
    code(1'b1);
    repeat (nb) put(8'h10, 1'b1, 1'b0, 1'b0);
    code(1'b0);
    repeat (na) put(8'h80, 1'b1, 1'b0, 1'b0);
    put(8'h00, 1'b0, 1'b0, 1'b0);
  endtask : yc_line
endmodule : vlg_pix_src
`default_nettype wire

// ===== verification/video_capture_line_geometry_tb.sv
// Bench of the line geometry block: registers, raw and Y/C lines
`default_nettype none
`include "vlg_params.svh"
`define CHK(got, exp, msg) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp); \
    end \
  end
module video_capture_line_geometry_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  mclk_in;
  logic                  rst_in;
  vlg_pkg::vlg_axi_req_s axi_req;
  vlg_pkg::vlg_axi_rsp_s axi_rsp;
  logic                  pix_vld;
  logic [7:0]            pix_data;
  logic                  line_start;
  logic                  frame_start;
  vlg_pkg::vlg_geo_s     geo;
  vlg_pkg::vlg_geo_s     geo_ch1;
  int                    mismatches;
  int                    samples_checked;
  int                    n_act;
  int                    n_blk;
  int                    a0;
  int                    b0;
  logic [31:0]           rdata;
  logic [1:0]            resp;
  logic [31:0]           ofs[4] = '{`VLG_OFS_IMG_PITCH, `VLG_OFS_HANC_PITCH, `VLG_OFS_HSIZE,
                                    `VLG_OFS_VMARKS0};
  logic [31:0]           msk[4] = '{32'hffff_ffff, 32'hffff_ffff, `VLG_HSIZE_MASK,
                                    `VLG_VMARKS_MASK};
  logic [31:0]           ctl[3] = '{32'h0000_0009, 32'h0000_000b, 32'h0000_0008};
  logic [31:0]           e_img[3] = '{32'h0000_1200, 32'h0000_1200, 32'h0000_1000};
  logic [31:0]           e_img1[3] = '{32'h0000_1e00, 32'h0000_1e00, 32'h0000_1000};
  logic [31:0]           e_vanc[3] = '{32'h0000_1200, 32'h0000_1400, 32'h0000_1000};
  logic [31:0]           e_hanc[3] = '{32'h0000_1080, 32'h0000_1080, 32'h0000_1000};

  vlg_top #(.CHANNEL(0)) u_dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .axi_req_in(axi_req), .axi_rsp_out(axi_rsp),
    .pix_vld_in(pix_vld), .pix_data_in(pix_data), .line_start_in(line_start),
    .frame_start_in(frame_start), .ch0_pitch_in(32'h0000_0700), .geo_out(geo));
  // Second channel borrows the channel zero pitch in raw mode
  vlg_top #(.CHANNEL(1)) u_dut_ch1 (
    .mclk_in(mclk_in), .rst_in(rst_in), .axi_req_in(axi_req), .axi_rsp_out(),
    .pix_vld_in(pix_vld), .pix_data_in(pix_data), .line_start_in(line_start),
    .frame_start_in(frame_start), .ch0_pitch_in(32'h0000_0700), .geo_out(geo_ch1));
  vlg_pix_src u_src (
    .mclk_in(mclk_in), .vld_out(pix_vld), .data_out(pix_data),
    .line_start_out(line_start), .frame_start_out(frame_start));

  initial
  begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in)
  begin
    n_act = n_act + int'(geo.active === 1'b1);
    n_blk = n_blk + int'(geo.blank === 1'b1);
  end

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.bready <= 1'b1;
    do
    begin
      @(posedge mclk_in);
      if (axi_req.awvalid && axi_rsp.awready)
        axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready)
        axi_req.wvalid <= 1'b0;
    end
    while (axi_rsp.bvalid !== 1'b1);
    resp = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a);
    @(posedge mclk_in);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    do
    begin
      @(posedge mclk_in);
      if (axi_req.arvalid && axi_rsp.arready)
        axi_req.arvalid <= 1'b0;
    end
    while (axi_rsp.rvalid !== 1'b1);
    rdata = axi_rsp.rdata;
    resp = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask : rd
  task automatic settle();
    repeat (4) @(posedge mclk_in);
    #1;
  endtask : settle
  task automatic conclude();
    $display("Counts: %0d checked, %0d mismatches", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (20000) @(posedge mclk_in);
    mismatches++;
    conclude();
  end

  initial
  begin
    rst_in = 1'b1;
    axi_req = '0;
    mismatches = 0;
    samples_checked = 0;
    n_act = 0;
    n_blk = 0;
    repeat (5) @(posedge mclk_in);
    rst_in <= 1'b0;
    for (int a = 0; a <= 20; a += 4)
    begin
      rd(32'(a));
      `CHK(rdata, `VLG_RST_REG, "reset value")
    end
    // Status shows the line counter, which starts at one
    rd(`VLG_OFS_STATUS);
    `CHK(rdata, 32'h0000_0001, "status after reset")
    rd(32'h0000_001c);
    `CHK(resp, `VLG_RESP_SLVERR, "unmapped read")
    wr(32'h0000_001c, 32'hffff_ffff);
    `CHK(resp, `VLG_RESP_SLVERR, "unmapped write")
    for (int i = 0; i < 4; i++)
    begin
      wr(ofs[i], 32'hffff_ffff);
      `CHK(resp, `VLG_RESP_OKAY, "mapped write")
      rd(ofs[i]);
      `CHK(resp, `VLG_RESP_OKAY, "mapped read")
      `CHK(rdata, msk[i], "register access")
    end
    $display("TEST registers done");
    wr(`VLG_OFS_HSIZE, 32'h0002_0004);
    for (int f = 2; f <= 3; f++)
    begin
      wr(`VLG_OFS_CTRL, 32'(f << 2) | 32'h1);
      u_src.frame();
      settle();
      a0 = n_act;
      b0 = n_blk;
      u_src.raw_line(8);
      settle();
      `CHK(n_blk - b0, 2, "raw blank bytes")
      `CHK(n_act - a0, 4, "raw active bytes")
      `CHK(geo.data, 8'hd8, "byte passed one cycle later")
    end
    $display("TEST raw timing done");
    wr(`VLG_OFS_IMG_PITCH, 32'h0000_0100);
    wr(`VLG_OFS_HANC_PITCH, 32'h0000_0040);
    wr(`VLG_OFS_AREA_START, 32'h0000_1000);
    wr(`VLG_OFS_VMARKS0, 32'h0003_0002);
    for (int i = 0; i < 3; i++)
    begin
      wr(`VLG_OFS_CTRL, ctl[i]);
      u_src.frame();
      repeat (3) u_src.raw_line(8);
      settle();
      `CHK(geo.line, 12'h003, "line number")
      `CHK(geo.img_addr, e_img[i], "image address")
      `CHK(geo_ch1.img_addr, e_img1[i], "channel zero pitch in raw")
      `CHK(geo.vanc_addr, e_vanc[i], "vertical ancillary address")
      `CHK(geo.hanc_addr, e_hanc[i], "horizontal ancillary address")
    end
    `CHK(geo.mark_a, 1'b1, "mark a on line 3")
    `CHK(geo.mark_b, 1'b0, "mark b off line 3")
    wr(`VLG_OFS_VMARKS0, 32'h0001_0003);
    settle();
    `CHK(geo.mark_a, 1'b0, "mark a moved")
    `CHK(geo.mark_b, 1'b1, "mark b moved")
    $display("TEST addresses and marks done");
    wr(`VLG_OFS_HSIZE, 32'h0004_0006);
    wr(`VLG_OFS_CTRL, 32'h0000_0001);
    wr(`VLG_OFS_STATUS, 32'h8000_0000);
    u_src.frame();
    settle();
    a0 = n_act;
    repeat (2) u_src.yc_line(4, 6);
    settle();
    `CHK(n_act - a0, 12, "Y/C active bytes")
    rd(`VLG_OFS_STATUS);
    `CHK(rdata[31], 1'b0, "no width mismatch")
    u_src.yc_line(5, 6);
    settle();
    rd(`VLG_OFS_STATUS);
    `CHK(rdata[31], 1'b1, "width mismatch flagged")
    wr(`VLG_OFS_STATUS, 32'h8000_0000);
    rd(`VLG_OFS_STATUS);
    `CHK(rdata[31], 1'b0, "mismatch cleared")
    $display("TEST Y/C timing done");
    conclude();
  end
endmodule : video_capture_line_geometry_tb
`default_nettype wire
